/* File: rtl/urx_status.sv */
// Purpose: receive fifo and status flags of a fifo serial port
// Assumes: characters arrive from a receive shifter with data and fault
//          bits; all inputs synchronous to mclk_in
// Notes:   register read data appear one cycle after rd_in, else zero
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps

module urx_status #(
  parameter int unsigned FIFO_DEPTH = urx_pkg::FIFO_DEPTH,
  parameter int unsigned ETU_CYCLES = urx_pkg::ETU_CYCLES
) (
  input  wire logic       mclk_in,     // 125 MHz clock
  input  wire logic       rstn_in,     // sync reset, active low
  input  wire logic       standby_in,  // standby, clears like reset
  input  wire logic [3:0] addr_in,     // register index
  input  wire logic [7:0] wdata_in,    // write data
  input  wire logic       wr_in,       // write strobe
  input  wire logic       rd_in,       // read strobe
  output logic      [7:0] rdata_out,   // read data, cycle after rd_in
  input  wire logic       dma_rd_in,   // dma fifo read strobe
  output logic      [7:0] dma_data_out,// dma read data, cycle after
  input  wire logic       ch_valid_in, // character from shifter valid
  output logic            ch_ready_out,// buffer can take a character
  input  wire logic [7:0] ch_data_in,  // received character
  input  wire logic       ch_fer_in,   // character framing fault
  input  wire logic       ch_per_in,   // character parity fault
  input  wire logic       rx_line_in,  // receive line level, 1 = mark
  output logic            rx_fill_out, // fill flag, dma request
  output logic            rx_idle_out, // idle ready flag
  output logic            overrun_out  // overrun flag
);
  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);
  localparam int unsigned PW = $clog2(FIFO_DEPTH);
  localparam int unsigned EW = urx_pkg::ENT_W;
  localparam logic [urx_pkg::DIV_W-1:0] DIV_RESET =
    urx_pkg::DIV_W'(ETU_CYCLES);
  localparam logic [4:0] IDLE_MAX = 5'(urx_pkg::IDLE_ETU);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255 ||
      (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
    $error("FIFO_DEPTH must be a power of two from 2 to 255");
  end
  if (ETU_CYCLES < 1 || ETU_CYCLES >= (1 << urx_pkg::DIV_W)) begin
    $error("ETU_CYCLES out of divider range");
  end

  function automatic logic [7:0] trig_num(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_num = urx_pkg::TRIG_SEL0;
      2'h1:    trig_num = urx_pkg::TRIG_SEL1;
      2'h2:    trig_num = urx_pkg::TRIG_SEL2;
      default: trig_num = urx_pkg::TRIG_SEL3;
    endcase
  endfunction

  // two-entry skid buffer between shifter and fifo
  logic [EW-1:0] sk_mem [2];
  logic          sk_wp_r;
  logic          sk_rp_r;
  logic [1:0]    sk_cnt_r;
  logic [1:0]    sk_cnt_nxt;

  // receive fifo
  logic [EW-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] fifo_wp_r;
  logic [PW-1:0] fifo_rp_r;
  logic [CW-1:0] fifo_cnt_r;

  // registers and flags
  logic [7:0]    ctrl_r;
  logic [urx_pkg::DIV_W-1:0] div_r;
  logic [urx_pkg::DIV_W-1:0] etu_cnt_r;
  logic [4:0]    idle_cnt_r;
  logic          brk_r;
  logic          fer_r;
  logic          per_r;
  logic          rdf_r;
  logic          dr_r;
  logic          ovr_r;
  logic          brk_arm_r;
  logic          rdf_arm_r;
  logic          ovr_arm_r;
  logic          prev_fer_r;
  logic [7:0]    rdata_r;
  logic [7:0]    dma_data_r;
  logic          rdf_nxt;
  logic          dr_nxt;
  urx_pkg::urx_state_t state_r;
  urx_pkg::urx_state_t state_nxt;

  wire clr_all = !rstn_in || standby_in;

  // skid buffer handshakes
  wire           sk_in_take  = ch_valid_in && ch_ready_out;
  wire           sk_out_vld  = sk_cnt_r != 2'h0;
  wire [EW-1:0]  sk_head     = sk_mem[sk_rp_r];
  wire [7:0]     sk_head_dat = sk_head[7:0];
  wire           sk_head_fer = sk_head[urx_pkg::ENT_FER];

  // fifo pop from cpu or dma; a push waits while a pop is requested, even with the fifo empty
  wire fifo_empty = fifo_cnt_r == CW'(0);
  wire fifo_full  = fifo_cnt_r == CW'(FIFO_DEPTH);
  wire cpu_fifo_rd = rd_in && (addr_in == urx_pkg::ADR_FIFO);
  wire pop_req    = cpu_fifo_rd || dma_rd_in;
  wire pop        = pop_req && !fifo_empty;
  wire sk_drain   = sk_out_vld && !pop_req;

  wire in_break   = state_r == urx_pkg::URX_BREAK;
  wire drop_brk   = in_break && (sk_head_dat == urx_pkg::BREAK_CHAR);
  wire ovr_evt    = sk_drain && !drop_brk && fifo_full;
  wire push       = sk_drain && !drop_brk && !fifo_full;
  wire brk_evt    = sk_drain && sk_head_fer && prev_fer_r &&
                    (sk_head_dat == urx_pkg::BREAK_CHAR);

  wire [EW-1:0] fifo_head = fifo_mem[fifo_rp_r];
  wire [CW-1:0] cnt_after = pop ? fifo_cnt_r - CW'(1) : fifo_cnt_r;

  // count compare against selected trigger
  wire [7:0] count8  = 8'(fifo_cnt_r);
  wire [7:0] after8  = 8'(cnt_after);
  wire [7:0] trig    = trig_num(ctrl_r[urx_pkg::CTRL_TRG_HI:
                                       urx_pkg::CTRL_TRG_LO]);
  wire at_trig       = count8 >= trig;
  wire below_after   = after8 < trig;

  // status register access
  wire st_wr = wr_in && (addr_in == urx_pkg::ADR_STATUS);
  wire st_rd = rd_in && (addr_in == urx_pkg::ADR_STATUS);
  wire clr_brk = st_wr && !wdata_in[urx_pkg::ST_BRK] && brk_arm_r;
  wire clr_rdf = st_wr && !wdata_in[urx_pkg::ST_RDF] && rdf_arm_r &&
                 !at_trig;
  wire clr_ovr = st_wr && !wdata_in[urx_pkg::ST_OVR] && ovr_arm_r;
  wire clr_dr  = st_wr && !wdata_in[urx_pkg::ST_DR];

  // bit period divider; a zero divisor runs as one
  wire etu_tick = etu_cnt_r + urx_pkg::DIV_W'(1) >= div_r;
  wire idle_rst = sk_in_take || !rx_line_in;
  wire idle_hit = idle_cnt_r == IDLE_MAX;

  wire [7:0] status_rd = {2'h0, ovr_r, brk_r, fer_r, per_r, rdf_r, dr_r};
  logic [7:0] rd_mux;

  always_comb begin
    case (addr_in)
      urx_pkg::ADR_STATUS: rd_mux = status_rd;
      urx_pkg::ADR_FIFO:   rd_mux = fifo_head[7:0];
      urx_pkg::ADR_COUNT:  rd_mux = count8;
      urx_pkg::ADR_CTRL:   rd_mux = ctrl_r;
      urx_pkg::ADR_DIV_LO: rd_mux = div_r[7:0];
      urx_pkg::ADR_DIV_HI: rd_mux = div_r[15:8];
      default:             rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    sk_cnt_nxt = sk_cnt_r;
    if (sk_in_take && !sk_drain)
      sk_cnt_nxt = sk_cnt_r + 2'h1;
    else if (!sk_in_take && sk_drain)
      sk_cnt_nxt = sk_cnt_r - 2'h1;
  end

  // break tracking
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      urx_pkg::URX_NORMAL:
        if (brk_evt)
          state_nxt = urx_pkg::URX_BREAK;
      urx_pkg::URX_BREAK:
        if (rx_line_in)
          state_nxt = urx_pkg::URX_NORMAL;
      default:
        state_nxt = urx_pkg::URX_NORMAL;
    endcase
  end

  // set terms first so an event beats a clear in the same cycle
  always_comb begin
    if (at_trig && !below_after)
      rdf_nxt = 1'b1;
    else if (dma_rd_in && pop && below_after)
      rdf_nxt = 1'b0;
    else if (clr_rdf)
      rdf_nxt = 1'b0;
    else
      rdf_nxt = rdf_r;
  end

  always_comb begin
    if (idle_hit && !at_trig && !fifo_empty)
      dr_nxt = 1'b1;
    else if (clr_dr)
      dr_nxt = 1'b0;
    else
      dr_nxt = dr_r;
  end

  assign ch_ready_out = sk_cnt_r != 2'h2;
  assign rdata_out    = rdata_r;
  assign dma_data_out = dma_data_r;
  assign rx_fill_out  = rdf_r;
  assign rx_idle_out  = dr_r;
  assign overrun_out  = ovr_r;

  // storage arrays carry no reset
  always_ff @(posedge mclk_in) begin
    if (sk_in_take)
      sk_mem[sk_wp_r] <= {ch_per_in, ch_fer_in, ch_data_in};
    if (push)
      fifo_mem[fifo_wp_r] <= sk_head;
  end

  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      sk_wp_r  <= 1'b0;
      sk_rp_r  <= 1'b0;
      sk_cnt_r <= 2'h0;
    end else begin
      sk_cnt_r <= sk_cnt_nxt;
      if (sk_in_take)
        sk_wp_r <= !sk_wp_r;
      if (sk_drain)
        sk_rp_r <= !sk_rp_r;
    end
  end

  // empty reads leave pointers alone and return stale data
  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      fifo_wp_r  <= '0;
      fifo_rp_r  <= '0;
      fifo_cnt_r <= '0;
    end else begin
      if (push)
        fifo_wp_r <= fifo_wp_r + PW'(1);
      if (pop)
        fifo_rp_r <= fifo_rp_r + PW'(1);
      if (push)
        fifo_cnt_r <= fifo_cnt_r + CW'(1);
      else if (pop)
        fifo_cnt_r <= fifo_cnt_r - CW'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      ctrl_r <= urx_pkg::CTRL_RESET;
      div_r  <= DIV_RESET;
    end else if (wr_in) begin
      if (addr_in == urx_pkg::ADR_CTRL)
        ctrl_r <= wdata_in;
      if (addr_in == urx_pkg::ADR_DIV_LO)
        div_r[7:0] <= wdata_in;
      if (addr_in == urx_pkg::ADR_DIV_HI)
        div_r[15:8] <= wdata_in;
    end
  end

  // idle timeout counted in ticks of the free-running bit divider, held off by a start bit
  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      etu_cnt_r  <= '0;
      idle_cnt_r <= 5'h00;
    end else begin
      etu_cnt_r <= etu_tick ? '0 : etu_cnt_r + urx_pkg::DIV_W'(1);
      if (idle_rst)
        idle_cnt_r <= 5'h00;
      else if (etu_tick && !idle_hit)
        idle_cnt_r <= idle_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      state_r    <= urx_pkg::URX_NORMAL;
      prev_fer_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (sk_drain)
        prev_fer_r <= sk_head_fer;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      brk_r <= 1'b0;
      ovr_r <= 1'b0;
      rdf_r <= 1'b0;
      dr_r  <= 1'b0;
    end else begin
      rdf_r <= rdf_nxt;
      dr_r  <= dr_nxt;
      if (brk_evt)
        brk_r <= 1'b1;
      else if (clr_brk)
        brk_r <= 1'b0;
      if (ovr_evt)
        ovr_r <= 1'b1;
      else if (clr_ovr)
        ovr_r <= 1'b0;
    end
  end

  // a status read showing a one arms its zero-write clear
  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      brk_arm_r <= 1'b0;
      rdf_arm_r <= 1'b0;
      ovr_arm_r <= 1'b0;
    end else begin
      if (st_rd && brk_r)
        brk_arm_r <= 1'b1;
      else if (clr_brk)
        brk_arm_r <= 1'b0;
      if (st_rd && rdf_r)
        rdf_arm_r <= 1'b1;
      else if (clr_rdf || !rdf_r)
        rdf_arm_r <= 1'b0;
      if (st_rd && ovr_r)
        ovr_arm_r <= 1'b1;
      else if (clr_ovr)
        ovr_arm_r <= 1'b0;
    end
  end

  // fault flags follow the character just read out
  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      fer_r <= 1'b0;
      per_r <= 1'b0;
    end else if (pop) begin
      fer_r <= fifo_head[urx_pkg::ENT_FER];
      per_r <= fifo_head[urx_pkg::ENT_PER];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (clr_all) begin
      rdata_r    <= 8'h00;
      dma_data_r <= 8'h00;
    end else begin
      rdata_r <= rd_in ? rd_mux : 8'h00;
      if (dma_rd_in)
        dma_data_r <= fifo_head[7:0];
    end
  end
endmodule

/* File: inc/urx_pkg.sv */
// Purpose: shared constants for the receive status flag block
// Assumes: 8-bit register port, 125 MHz mclk_in
// Notes:   offsets are register indices on the plain register port
package urx_pkg;
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // default line rate; the bit period is software-programmable later
  localparam int unsigned BAUD_DEFAULT = 115_200;
  localparam int unsigned ETU_CYCLES   = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned IDLE_ETU     = 16;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_W  = 16;

  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_FIFO   = 4'h1;
  localparam logic [3:0] ADR_COUNT  = 4'h2;
  localparam logic [3:0] ADR_CTRL   = 4'h3;
  localparam logic [3:0] ADR_DIV_LO = 4'h4;
  localparam logic [3:0] ADR_DIV_HI = 4'h5;

  // status register bit positions
  localparam int unsigned ST_DR  = 0;
  localparam int unsigned ST_RDF = 1;
  localparam int unsigned ST_PER = 2;
  localparam int unsigned ST_FER = 3;
  localparam int unsigned ST_BRK = 4;
  localparam int unsigned ST_OVR = 5;

  // fifo control register: receive trigger select field
  localparam int unsigned CTRL_TRG_LO = 6;
  localparam int unsigned CTRL_TRG_HI = 7;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;

  // trigger numbers selected by the two-bit field
  localparam logic [7:0] TRIG_SEL0 = 8'h01;
  localparam logic [7:0] TRIG_SEL1 = 8'h04;
  localparam logic [7:0] TRIG_SEL2 = 8'h08;
  localparam logic [7:0] TRIG_SEL3 = 8'h0e;

  localparam logic [7:0] BREAK_CHAR = 8'h00;

  // fifo entry layout: data, framing fault, parity fault
  localparam int unsigned ENT_W   = 10;
  localparam int unsigned ENT_FER = 8;
  localparam int unsigned ENT_PER = 9;

  typedef enum logic [0:0] {
    URX_NORMAL,
    URX_BREAK
  } urx_state_t;
endpackage

/* File: tb/urx_status_asserts.sv */
// Purpose: port checks of urx_status
// Assumes: one clock domain, bound from the bench
// Notes:   idle bound allows one bit tick of phase slack
`timescale 1ns/100ps
module urx_status_asserts #(
  parameter int unsigned ETU_CYCLES = 4
) (
  input wire logic       mclk_in,      // clock
  input wire logic       rstn_in,      // reset, active low
  input wire logic       standby_in,   // standby
  input wire logic [3:0] addr_in,      // index
  input wire logic [7:0] wdata_in,     // write data
  input wire logic       wr_in,        // write strobe
  input wire logic       rd_in,        // read strobe
  input wire logic [7:0] rdata_out,    // read data
  input wire logic       dma_rd_in,    // dma pop
  input wire logic [7:0] dma_data_out, // dma data
  input wire logic       ch_valid_in,  // char valid
  input wire logic       ch_ready_out, // char ready
  input wire logic       rx_line_in,   // line level
  input wire logic       rx_fill_out,  // fill flag
  input wire logic       rx_idle_out,  // idle flag
  input wire logic       overrun_out   // overrun flag
);
  localparam int QUIET_MIN = 15 * ETU_CYCLES;
  logic [15:0] quiet_r;
  logic [15:0] quiet_nxt;
  logic        st_wr;
  assign st_wr = wr_in && (addr_in == urx_pkg::ADR_STATUS);
  // cycles since the last take with the line at mark
  assign quiet_nxt = ((ch_valid_in && ch_ready_out) || !rx_line_in) ? '0 :
                     (quiet_r == 16'hffff) ? quiet_r : quiet_r + 16'h0001;
  always_ff @(posedge mclk_in) begin
    quiet_r <= (rstn_in && !standby_in) ? quiet_nxt : 16'h0000;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  property p_stby;
    standby_in |=> !rx_fill_out && !rx_idle_out && !overrun_out
                   && ch_ready_out;
  endproperty
  a_stby: assert property (p_stby) else $error("standby clear");
  property p_rd0; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("read data idle");
  property p_dma; !dma_rd_in && !standby_in |=> $stable(dma_data_out);
  endproperty
  a_dma: assert property (p_dma) else $error("dma data moved");
  property p_idle_q; $rose(rx_idle_out) |-> quiet_r >= QUIET_MIN; endproperty
  a_idle_q: assert property (p_idle_q) else $error("idle early");
  property p_idle_clr;
    $fell(rx_idle_out) |-> $past((st_wr && !wdata_in[0]) || standby_in);
  endproperty
  a_idle_clr: assert property (p_idle_clr) else $error("idle fell");
  property p_ovr_clr;
    $fell(overrun_out) |-> $past((st_wr && !wdata_in[5]) || standby_in);
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("ovr fell");
  property p_ovr_set;
    $rose(overrun_out) |-> $past(ch_valid_in) || $past(ch_valid_in, 2)
                           || $past(ch_valid_in, 3);
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("ovr rose");
  property p_fill;
    $fell(rx_fill_out) |-> $past(dma_rd_in || wr_in || standby_in);
  endproperty
  a_fill: assert property (p_fill) else $error("fill fell");
  property p_rdy; $fell(ch_ready_out) |-> $past(ch_valid_in); endproperty
  a_rdy: assert property (p_rdy) else $error("ready fell");
  c_ovr: cover property ($rose(overrun_out));
  c_idle: cover property ($rose(rx_idle_out));
  c_fill: cover property ($fell(rx_fill_out) && $past(dma_rd_in));
endmodule

/* File: tb/urx_tx_model.sv */
// Purpose: remote transmitter feeding the character stream
// Assumes: bench asks for one char at a time
// Notes:   released lines show the inverse of the last char
`timescale 1ns/100ps
module urx_tx_model (
  input  wire logic       mclk_in,      // clock
  input  wire logic       send_in,      // pulse: send char_in
  input  wire logic [9:0] char_in,      // {per, fer, data}
  input  wire logic       brk_in,       // hold line at space
  input  wire logic       ch_ready_in,  // block can take
  output logic            ch_valid_out, // char valid
  output logic      [9:0] char_out,     // {per, fer, data}
  output logic            rx_line_out   // line level
);
  assign rx_line_out = !brk_in;
  initial begin
    ch_valid_out = 1'b0;
    char_out     = 10'h3ff;
  end
  always @(posedge mclk_in) begin
    if (send_in) begin
      ch_valid_out <= 1'b1;
      char_out     <= char_in;
    end else if (ch_valid_out && ch_ready_in) begin
      ch_valid_out <= 1'b0;
      char_out     <= ~char_out;
    end
  end
endmodule

/* File: tb/urx_status_tb.sv */
// Purpose: self-checking bench of urx_status
// Assumes: short bit period parameter
// Notes:   reads are checked from a queue one cycle later
`timescale 1ns/100ps
module urx_status_tb;
  localparam int unsigned ETU = 4;
  logic       mclk_in, rx_line_in, ch_valid_in, ch_ready_out, rd_seen;
  logic       rstn_in = 0, standby_in = 0, wr_in = 0, rd_in = 0;
  logic       dma_rd_in = 0, send = 0, break_seen_flag = 0;
  logic       rx_fill_out, rx_idle_out, overrun_out;
  logic [3:0] addr_in = 0;
  logic [7:0] wdata_in = 0, rdata_out, dma_data_out, mk, trig;
  logic [9:0] tx_char = 0, ch_bus;
  logic [7:0] exp_q[$], msk_q[$], stored[16];
  logic [7:0] tbl[4] = '{urx_pkg::TRIG_SEL0, urx_pkg::TRIG_SEL1,
                         urx_pkg::TRIG_SEL2, urx_pkg::TRIG_SEL3};
  logic [31:0] seed = 32'h1fc6f02a;
  int         n_fail = 0, n_checks = 0, i, s;
  urx_status #(.ETU_CYCLES(ETU)) urx_status_i (.mclk_in, .rstn_in,
    .standby_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .dma_rd_in, .dma_data_out, .ch_valid_in, .ch_ready_out,
    .ch_data_in(ch_bus[7:0]), .ch_fer_in(ch_bus[8]), .ch_per_in(ch_bus[9]),
    .rx_line_in, .rx_fill_out, .rx_idle_out, .overrun_out);
  urx_tx_model urx_tx_model_i (.mclk_in, .send_in(send), .char_in(tx_char),
    .brk_in(break_seen_flag), .ch_ready_in(ch_ready_out), .ch_valid_out(ch_valid_in),
    .char_out(ch_bus), .rx_line_out(rx_line_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fl(input string nm, input int k, input logic e);
    logic [2:0] f;
    @(negedge mclk_in);
    f = {overrun_out, rx_idle_out, rx_fill_out};
    cmp(nm, {7'h00, e}, {7'h00, f[k]});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask
  // fixed wait covers take, drain to fifo and count update
  task automatic tx(input logic [9:0] c);
    @(posedge mclk_in);
    tx_char <= c;
    send    <= 1'b1;
    @(posedge mclk_in);
    send <= 1'b0;
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic pulse(input int k);
    @(posedge mclk_in);
    if (k == 0) dma_rd_in <= 1'b1;
    else standby_in <= 1'b1;
    @(posedge mclk_in);
    dma_rd_in  <= 1'b0;
    standby_in <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #(urx_pkg::CLK_PERIOD_NS / 2) mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) rd_seen <= rd_in;
  always @(negedge mclk_in) begin
    if (rd_seen && exp_q.size() > 0) begin
      mk = msk_q.pop_front();
      cmp("rdata", exp_q.pop_front() & mk, rdata_out & mk);
    end
  end
  initial begin
    #(20_000 * urx_pkg::CLK_PERIOD_NS);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd(urx_pkg::ADR_STATUS, 8'h00, 8'hff);
    rd(urx_pkg::ADR_COUNT, 8'h00, 8'hff);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00, 8'hff);
    rd(urx_pkg::ADR_DIV_LO, 8'(ETU), 8'hff);
    for (s = 0; s < 4; s++) begin
      pulse(1);
      wr(urx_pkg::ADR_CTRL, 8'(s << 6));
      rd(urx_pkg::ADR_CTRL, 8'(s << 6), 8'hff);
      trig = tbl[s];
      for (i = 1; i <= 16; i++) begin
        seed = xs(seed);
        stored[i-1] = seed[7:0];
        tx({2'b00, seed[7:0]});
        fl("fill", 0, i >= trig);
      end
      rd(urx_pkg::ADR_COUNT, 8'h10, 8'hff);
      tx(10'h0aa);
      fl("ovr", 2, 1'b1);
      rd(urx_pkg::ADR_COUNT, 8'h10, 8'hff);
      for (i = 15; i >= 0; i--) begin
        pulse(0);
        @(negedge mclk_in);
        cmp("dma", stored[15-i], dma_data_out);
        fl("fill", 0, i >= trig);
      end
    end
    pulse(1);
    wr(urx_pkg::ADR_CTRL, 8'hc0);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      stored[i] = seed[7:0];
      tx({i[1:0], seed[7:0]});
    end
    for (i = 0; i < 4; i++) begin
      rd(urx_pkg::ADR_FIFO, stored[i], 8'hff);
      rd(urx_pkg::ADR_STATUS, {4'h0, i[0], i[1], 2'b00}, 8'h0c);
    end
    pulse(1);
    wr(urx_pkg::ADR_CTRL, 8'h00);
    tx(10'h011);
    rd(urx_pkg::ADR_STATUS, 8'h02, 8'h02);
    wr(urx_pkg::ADR_STATUS, 8'h00);
    fl("fill", 0, 1'b1);
    rd(urx_pkg::ADR_FIFO, 8'h11, 8'hff);
    rd(urx_pkg::ADR_STATUS, 8'h02, 8'h02);
    wr(urx_pkg::ADR_STATUS, 8'h00);
    fl("fill", 0, 1'b0);
    pulse(1);
    wr(urx_pkg::ADR_CTRL, 8'hc0);
    tx(10'h021);
    tx(10'h022);
    repeat (10 * ETU) @(posedge mclk_in);
    fl("idle", 1, 1'b0);
    repeat (8 * ETU) @(posedge mclk_in);
    fl("idle", 1, 1'b1);
    rd(urx_pkg::ADR_FIFO, 8'h21, 8'hff);
    rd(urx_pkg::ADR_FIFO, 8'h22, 8'hff);
    wr(urx_pkg::ADR_STATUS, 8'h00);
    fl("idle", 1, 1'b0);
    pulse(1);
    wr(urx_pkg::ADR_CTRL, 8'h40);
    tx(10'h155);
    break_seen_flag <= 1'b1;
    repeat (4) tx(10'h100);
    rd(urx_pkg::ADR_STATUS, 8'h10, 8'h10);
    fl("fill", 0, 1'b0);
    break_seen_flag <= 1'b0;
    repeat (3) tx(10'h000);
    fl("fill", 0, 1'b1);
    wr(urx_pkg::ADR_STATUS, 8'h00);
    rd(urx_pkg::ADR_STATUS, 8'h00, 8'h10);
    pulse(1);
    // a held pop request stalls the drain, so the buffer fills up
    dma_rd_in <= 1'b1;
    tx(10'h031);
    tx(10'h032);
    @(negedge mclk_in);
    cmp("ready", 8'h00, {7'h00, ch_ready_out});
    @(posedge mclk_in);
    dma_rd_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    rd(urx_pkg::ADR_COUNT, 8'h02, 8'hff);
    repeat (4) @(posedge mclk_in);
    final_report();
  end
endmodule
bind urx_status urx_status_asserts #(.ETU_CYCLES(ETU_CYCLES))
  urx_status_asserts_i (.mclk_in, .rstn_in, .standby_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .dma_rd_in, .dma_data_out,
  .ch_valid_in, .ch_ready_out, .rx_line_in, .rx_fill_out, .rx_idle_out,
  .overrun_out);
